// ===== verilog/twp_regs.vh
// twp_regs.vh: constants of the two-wire master/slave port
// assumes: included by bare name from the design files
`ifndef TWP_REGS_VH
`define TWP_REGS_VH
`define TWP_LOW_PHASE 4'h6
`define TWP_HIGH_PHASE 4'h4
`define TWP_DIV_RESET 8'h0C
`define TWP_ADDR_RESET 7'h3C
`define TWP_FIFO_DEPTH 8
`define TWP_SYNC_STAGES 2
`endif

// ===== verilog/twp_fifo.v
// twp_fifo.v: small synchronous fifo, valid/ready both sides, registered read data
// assumes: one clock, synchronous active high reset
`timescale 1ns/1ps
module twp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire mclk,
	input wire rst,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output reg [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;
	wire load;
	assign in_ready = (count != DEPTH[AW:0]);
	assign push = in_valid && in_ready;
	// output register refills when empty or being drained
	assign load = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
	assign pop = load;
	always @(posedge mclk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	always @(posedge mclk) begin
		if (rst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
			if (load) begin
				out_data <= mem[rd_ptr];
				out_valid <= 1'b1;
			end else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule

// ===== verilog/twp_port.v
// twp_port.v: two-wire serial port with independent master and slave engines
// assumes: sda/scl open-drain pads outside; 25 MHz mclk; rx bytes drain via fifo
`timescale 1ns/1ps
`include "twp_regs.vh"
module twp_port #(
	parameter FIFO_DEPTH = `TWP_FIFO_DEPTH
) (
	input wire mclk,
	input wire rst,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire scl_in,
	output wire scl_out,
	output wire scl_oe,
	input wire [7:0] clock_divider_value,
	input wire m_start,
	input wire [6:0] m_addr,
	input wire m_read,
	input wire [7:0] m_tx_data,
	output reg m_busy,
	output reg m_done,
	output reg m_error,
	output wire [7:0] rx_data,
	output wire rx_valid,
	input wire rx_ready,
	input wire [6:0] s_addr,
	input wire [7:0] s_tx_data,
	output reg s_received,
	output reg s_requested,
	output reg bus_busy
);
	localparam M_IDLE = 6'h01, M_START = 6'h02, M_BIT = 6'h04;
	localparam M_ACK = 6'h08, M_STOP = 6'h10, M_DATA = 6'h20;
	localparam S_IDLE = 4'h1, S_BIT = 4'h2, S_ACK = 4'h4, S_SEND = 4'h8;
	reg [1:0] sda_sync;
	reg [1:0] scl_sync;
	reg sda_d;
	reg scl_d;
	wire sda = sda_sync[1];
	wire scl = scl_sync[1];
	// second stage only feeds logic; first stage stays private
	always @(posedge mclk) begin
		if (rst) begin
			sda_sync <= 2'b11;
			scl_sync <= 2'b11;
			sda_d <= 1'b1;
			scl_d <= 1'b1;
		end else begin
			sda_sync <= {sda_sync[0], sda_in};
			scl_sync <= {scl_sync[0], scl_in};
			sda_d <= sda;
			scl_d <= scl;
		end
	end
	wire start_seen = scl && scl_d && sda_d && !sda;
	wire stop_seen = scl && scl_d && !sda_d && sda;
	wire scl_rise = scl && !scl_d;
	wire scl_fall = !scl && scl_d;
	always @(posedge mclk) begin
		if (rst)
			bus_busy <= 1'b0;
		else if (start_seen)
			bus_busy <= 1'b1;
		else if (stop_seen)
			bus_busy <= 1'b0;
	end
	// receive fifo shared by both receive roles
	reg [7:0] fifo_in;
	reg fifo_push;
	wire fifo_ready;
	twp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_data(fifo_in),
		.in_valid(fifo_push),
		.in_ready(fifo_ready),
		.out_data(rx_data),
		.out_valid(rx_valid),
		.out_ready(rx_ready)
	);
	// phase unit lasts 2*(1+divider) system clocks; 9-bit count so 8'hFF still fits
	reg [8:0] pre_cnt;
	reg [3:0] phase;
	wire tick = (pre_cnt == {clock_divider_value, 1'b1});
	reg [5:0] m_state;
	reg [3:0] m_bit;
	reg [8:0] m_shift;
	reg m_sda_low;
	reg m_scl_low;
	reg m_addr_phase;
	reg m_rd;
	reg [7:0] fifo_in_m;
	// low phase 6 units, high phase 4 units
	wire phase_end = tick && (phase == (m_scl_low ? `TWP_LOW_PHASE : `TWP_HIGH_PHASE) - 4'h1);
	wire m_hold = !m_scl_low && !scl; // stretched clock
	always @(posedge mclk) begin
		if (rst) begin
			pre_cnt <= 9'h000;
		end else if (m_state == M_IDLE || tick || m_hold) begin
			pre_cnt <= 9'h000;
		end else begin
			pre_cnt <= pre_cnt + 9'h001;
		end
	end
	always @(posedge mclk) begin
		if (rst) begin
			m_state <= M_IDLE;
			phase <= 4'h0;
			m_bit <= 4'h0;
			m_shift <= 9'h1FF;
			m_sda_low <= 1'b0;
			m_scl_low <= 1'b0;
			m_addr_phase <= 1'b0;
			m_rd <= 1'b0;
			fifo_in_m <= 8'h00;
			m_busy <= 1'b0;
			m_done <= 1'b0;
			m_error <= 1'b0;
		end else begin
			m_done <= 1'b0;
			m_error <= 1'b0;
			if (tick && !m_hold)
				phase <= phase_end ? 4'h0 : phase + 4'h1;
			case (m_state)
			M_IDLE: begin
				phase <= 4'h0;
				if (m_start && !bus_busy && sda && scl) begin
					m_state <= M_START;
					m_busy <= 1'b1;
					m_sda_low <= 1'b1;
					m_rd <= m_read;
					m_shift <= {m_addr, m_read, 1'b1};
					m_addr_phase <= 1'b1;
					m_bit <= 4'h0;
				end
			end
			M_START: if (phase_end) begin
				m_scl_low <= 1'b1;
				m_state <= M_BIT;
			end
			// data moves mid low phase, never on a clock edge
			M_BIT: if (m_scl_low && tick && phase == 4'h2) begin
				m_sda_low <= !m_shift[8];
			end else if (phase_end) begin
				if (m_scl_low)
					m_scl_low <= 1'b0;
				else begin
					// lost arbitration: released line seen low; ack slot belongs to the far side
					if (!m_sda_low && !sda && m_bit < 4'h8 && !(m_rd && !m_addr_phase)) begin
						m_error <= 1'b1;
						m_busy <= 1'b0;
						m_sda_low <= 1'b0;
						m_state <= M_IDLE;
					end else begin
						m_shift <= {m_shift[7:0], sda};
						m_scl_low <= 1'b1;
						m_bit <= m_bit + 4'h1;
						if (m_bit == 4'h8)
							m_state <= M_ACK;
					end
				end
			end
			M_ACK: begin
				m_bit <= 4'h0;
				if (m_rd && !m_addr_phase) begin
					fifo_in_m <= m_shift[8:1];
					m_shift <= 9'h1FF; // single byte read: master nacks
				end
				if (!m_rd || m_addr_phase ? m_shift[0] : 1'b0) begin
					m_error <= 1'b1; // nack from slave
					m_sda_low <= 1'b1; // data low under low clock, so stop edge is clean
					m_state <= M_STOP;
				end else if (m_addr_phase) begin
					m_addr_phase <= 1'b0;
					m_shift <= m_rd ? 9'h1FF : {m_tx_data, 1'b1};
					m_state <= M_BIT;
				end else begin
					m_done <= 1'b1;
					m_sda_low <= 1'b1;
					m_state <= M_STOP;
				end
			end
			M_STOP: if (phase_end) begin
				if (m_scl_low) begin
					m_sda_low <= 1'b1;
					m_scl_low <= 1'b0;
				end else begin
					m_sda_low <= 1'b0;
					m_busy <= 1'b0;
					m_state <= M_IDLE;
				end
			end
			default: m_state <= M_IDLE;
			endcase
		end
	end
	reg m_push_req;
	always @(posedge mclk) begin
		if (rst)
			m_push_req <= 1'b0;
		else
			m_push_req <= (m_state == M_ACK) && m_rd && !m_addr_phase;
	end
	// slave engine runs beside the master
	reg [3:0] s_state;
	reg [3:0] s_bit;
	reg [7:0] s_shift;
	reg s_sda_low;
	reg s_scl_low;
	reg s_is_addr;
	reg s_tx;
	reg s_push_req;
	reg [7:0] s_byte;
	always @(posedge mclk) begin
		if (rst) begin
			s_state <= S_IDLE;
			s_bit <= 4'h0;
			s_shift <= 8'h00;
			s_sda_low <= 1'b0;
			s_scl_low <= 1'b0;
			s_is_addr <= 1'b0;
			s_tx <= 1'b0;
			s_push_req <= 1'b0;
			s_byte <= 8'h00;
			s_received <= 1'b0;
			s_requested <= 1'b0;
		end else begin
			s_received <= 1'b0;
			s_requested <= 1'b0;
			s_push_req <= 1'b0;
			// hold clock low while fifo is full; the byte's single push pulse is not retried, so it is dropped
			s_scl_low <= s_scl_low ? !fifo_ready : 1'b0;
			if (start_seen) begin
				s_state <= S_BIT;
				s_bit <= 4'h0;
				s_is_addr <= 1'b1;
				s_sda_low <= 1'b0;
			end else if (stop_seen) begin
				s_state <= S_IDLE;
				s_sda_low <= 1'b0;
			end else begin
				case (s_state)
				S_IDLE: s_sda_low <= 1'b0;
				S_BIT: if (scl_rise) begin
					s_shift <= {s_shift[6:0], sda};
					s_bit <= s_bit + 4'h1;
				end else if (scl_fall && s_bit == 4'h8) begin
					if (s_is_addr && s_shift[7:1] != s_addr) begin
						s_state <= S_IDLE;
					end else if (s_is_addr) begin
						s_sda_low <= 1'b1;
						s_tx <= s_shift[0];
						s_state <= S_ACK;
					end else begin
						s_sda_low <= 1'b1;
						s_byte <= s_shift;
						s_push_req <= 1'b1;
						s_received <= 1'b1;
						s_scl_low <= !fifo_ready;
						s_state <= S_ACK;
					end
				end
				S_ACK: if (scl_fall) begin
					s_is_addr <= 1'b0;
					s_bit <= 4'h0;
					if (s_tx) begin
						s_shift <= s_tx_data;
						s_sda_low <= !s_tx_data[7];
						s_requested <= 1'b1;
						s_state <= S_SEND;
					end else begin
						s_sda_low <= 1'b0;
						s_state <= S_BIT;
					end
				end
				S_SEND: if (scl_fall) begin
					s_bit <= s_bit + 4'h1;
					s_shift <= {s_shift[6:0], 1'b1};
					s_sda_low <= (s_bit < 4'h7) && !s_shift[6];
					if (s_bit == 4'h8)
						s_state <= sda ? S_IDLE : S_SEND;
					if (s_bit == 4'h8 && !sda) begin
						s_bit <= 4'h0;
						s_shift <= s_tx_data;
						s_sda_low <= !s_tx_data[7];
						s_requested <= 1'b1;
					end
				end else if (scl_rise && s_bit == 4'h8 && sda) begin
					s_state <= S_IDLE; // master nacked
				end
				default: s_state <= S_IDLE;
				endcase
			end
		end
	end
	always @* begin
		fifo_push = s_push_req || m_push_req;
		fifo_in = s_push_req ? s_byte : fifo_in_m;
	end
	// open-drain: only ever drive low
	assign sda_out = 1'b0;
	assign scl_out = 1'b0;
	assign sda_oe = m_sda_low || s_sda_low;
	assign scl_oe = m_scl_low || s_scl_low;
endmodule

// ===== sim/twp_port_checker.sv
// twp_port_checker.sv: assertions on the port's own outputs
// assumes: bound onto twp_port, one clock, sync reset
`timescale 1ns/1ps
module twp_port_checker (
	input wire mclk,
	input wire rst,
	input wire sda_out,
	input wire sda_oe,
	input wire scl_out,
	input wire scl_oe,
	input wire [7:0] clock_divider_value,
	input wire m_busy,
	input wire m_done,
	input wire m_error,
	input wire bus_busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [15:0] pcnt;
	logic seen;
	// pad sync may stretch the high phase by a few cycles
	always @(posedge mclk) begin
		if (rst || !m_busy) begin
			pcnt <= 16'h0;
			seen <= 1'b0;
		end else if ($rose(scl_oe)) begin
			pcnt <= 16'h1;
			seen <= 1'b1;
		end else begin
			pcnt <= pcnt + 16'h1;
		end
	end
	a_pads_only_low: assert property (!sda_out && !scl_out)
		else $error("pad drives high");
	a_clock_period: assert property ($rose(scl_oe) && seen |->
		(int'(pcnt) - 20 * (1 + int'(clock_divider_value))) inside {[0:3]})
		else $error("clock period wrong");
	a_done_pulse: assert property (m_done |=> !m_done)
		else $error("done longer than one cycle");
	a_error_pulse: assert property (m_error |=> !m_error)
		else $error("error longer than one cycle");
	a_done_err_excl: assert property (!(m_done && m_error))
		else $error("done and error together");
	a_end_in_busy: assert property (m_done || m_error |-> $past(m_busy))
		else $error("event outside a transfer");
	a_start_idle: assert property ($rose(m_busy) |-> !$past(bus_busy))
		else $error("master started on busy bus");
	a_start_order: assert property ($rose(sda_oe) && !scl_oe && !bus_busy |=> !scl_oe [*3])
		else $error("clock pulled too soon after start");
	c_done: cover property (m_done);
	c_error: cover property (m_error);
	c_period: cover property ($rose(scl_oe) && seen);
endmodule

// ===== sim/twp_slave_model.sv
// twp_slave_model.sv: behavioural bus slave on the far side
// assumes: bench resolves lines with pull-ups; never stretches the clock
`timescale 1ns/1ps
module twp_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input wire scl,
	input wire sda,
	input wire [7:0] tx_byte,
	output logic pull,
	output logic [7:0] got
);
	logic [7:0] sh = 8'h00;
	int cnt = 0;
	int ph = 2;
	logic sel = 1'b0;
	logic rd = 1'b0;
	initial pull = 1'b0;
	initial got = 8'h00;
	always @(negedge sda) if (scl) begin
		cnt = 0;
		ph = 0;
	end
	always @(posedge sda) if (scl) ph = 2;
	always @(posedge scl) if (ph < 2) begin
		sh = {sh[6:0], sda};
		cnt = cnt + 1;
	end
	// only pulls low or releases: pull-up gives the high level
	always @(negedge scl) if (ph < 2) begin
		if (cnt == 8) begin
			if (ph == 0) begin
				sel = (sh[7:1] == ADDR);
				rd = sh[0];
			end else if (!rd && sel) begin
				got = sh;
			end
			pull = sel && !(ph == 1 && rd);
		end else if (cnt == 9) begin
			cnt = 0;
			ph = ph + 1;
			pull = 1'b0;
		end
		if (ph == 1 && rd && sel && cnt < 8) pull = !tx_byte[7 - cnt];
	end
endmodule

// ===== sim/tb.sv
// tb.sv: self-checking bench, port against a model slave and its own slave
// assumes: checker and slave model compiled first
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] div = 8'h00;
	logic m_start = 1'b0;
	logic [6:0] m_addr = 7'h00;
	logic m_read = 1'b0;
	logic [7:0] m_tx = 8'h00;
	logic rx_ready = 1'b0;
	logic [7:0] s_tx = 8'h00;
	logic [31:0] r = 32'hEBFA;
	wire sda_oe, scl_oe, pull, m_busy, m_done, m_error, rx_valid, s_rcv, s_req, bus_busy;
	wire [7:0] rx_data, got;
	wire sda = !(sda_oe || pull);
	wire scl = !scl_oe;
	int fails = 0;
	int check_count = 0;
	int n_rcv = 0;
	int n_req = 0;
	logic exp_q[$];
	logic [7:0] rx_q[$];
	always #20 mclk = ~mclk;
	twp_port i_dut (.mclk, .rst, .sda_in(sda), .sda_out(), .sda_oe, .scl_in(scl),
		.scl_out(), .scl_oe, .clock_divider_value(div), .m_start, .m_addr, .m_read,
		.m_tx_data(m_tx), .m_busy, .m_done, .m_error, .rx_data, .rx_valid, .rx_ready,
		.s_addr(7'h11), .s_tx_data(s_tx), .s_received(s_rcv), .s_requested(s_req),
		.bus_busy);
	twp_slave_model i_mdl (.scl, .sda, .tx_byte(8'hC8), .pull, .got);
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_flag(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t: status %b expected %b", $time, g, e);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// level request held until taken; one byte per transfer
	task automatic xfer(input logic rd, input logic [6:0] a, input logic err,
		input logic [7:0] e);
		exp_q.push_back(err);
		if (!err && (rd || a == 7'h11)) rx_q.push_back(e);
		m_read <= rd;
		m_addr <= a;
		m_tx <= e;
		m_start <= 1'b1;
		do @(negedge mclk); while (m_busy !== 1'b1);
		@(posedge mclk) m_start <= 1'b0;
		do @(negedge mclk); while (m_busy !== 1'b0 || bus_busy !== 1'b0);
		@(posedge mclk);
	endtask
	// receiver side stalls at random
	always @(posedge mclk) begin
		if (m_done || m_error) chk_flag(m_error, exp_q.pop_front());
		if (rx_valid && rx_ready) chk(rx_data, rx_q.pop_front());
		if (s_rcv === 1'b1) n_rcv++;
		if (s_req === 1'b1) n_req++;
		r <= nx(r);
		rx_ready <= r[3];
	end
	initial begin
		logic [7:0] d;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			div <= 8'(2 * k);
			s_tx <= r[15:8];
			d = r[7:0];
			@(posedge mclk);
			xfer(1'b0, 7'h2A, 1'b0, d);
			chk(got, d);
			xfer(1'b1, 7'h2A, 1'b0, 8'hC8);
			xfer(1'b0, 7'h33, 1'b1, d);
			xfer(1'b0, 7'h11, 1'b0, d);
			xfer(1'b1, 7'h11, 1'b0, s_tx);
			$display("test div=%0d done", 2 * k);
		end
		repeat (40) @(posedge mclk);
		chk(8'(n_rcv), 8'h02);
		chk(8'(n_req), 8'h02);
		chk(8'(rx_q.size()), 8'h00);
		final_report();
	end
	initial begin
		repeat (40000) @(posedge mclk);
		fails++;
		final_report();
	end
endmodule
bind twp_port twp_port_checker i_chk (.mclk, .rst, .sda_out, .sda_oe, .scl_out, .scl_oe,
	.clock_divider_value, .m_busy, .m_done, .m_error, .bus_busy);
